// ---- core/asr_host.sv ----
// Host controller driving a 128K x 8 asynchronous static RAM
`timescale 1ns/1ps
`include "asr_map.svh"
// Summary of operation
// - No clock reaches the memory; only control levels steer it.
// - Address and select valid at least 7 ns before write end.
// - Data set up 5 ns before write end; strobe low 7 ns.
// - With enable low, strobe pulse covers turn-off plus data set-up.
// - With enable high only the plain write pulse is needed.
// - Host never drives data while memory still drives the bus.
// - Select stays low for the whole chip-select-to-end interval.
// - Address valid no later than select falling for reads.
module asr_host (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // User request side
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [`ASR_ADDR_W-1:0] reqAddr,
  input wire logic [`ASR_DATA_W-1:0] reqWdata,
  output logic reqReady,
  output logic rdValid,
  output logic [`ASR_DATA_W-1:0] rdData,
  // Memory pins
  output logic [`ASR_ADDR_W-1:0] memAddr,
  output logic memCsN,
  output logic memOeN,
  output logic memWeN,
  input wire logic [`ASR_DATA_W-1:0] memDataIn,
  output logic [`ASR_DATA_W-1:0] memDataOut,
  output logic memDataOeN
);
  localparam logic [`ASR_CNT_W-1:0] RdCyc = `ASR_CNT_W'(`ASR_RD_CYC);
  localparam logic [`ASR_CNT_W-1:0] WpCyc = `ASR_CNT_W'(`ASR_WP_CYC);
  localparam logic [`ASR_CNT_W-1:0] RecCyc = `ASR_CNT_W'(`ASR_REC_CYC);

  asr_pkg::asr_state_t state_r;
  logic [`ASR_CNT_W-1:0] cnt_r;
  logic [`ASR_DATA_W-1:0] dinMeta_r;
  logic [`ASR_DATA_W-1:0] dinSync_r;
  logic wasRead_r;

  // ----------------------------------------------------------
  // Read data synchroniser
  // ----------------------------------------------------------
  // Pins are asynchronous to ref_clk, so two stages before sampling
  always_ff @(posedge ref_clk)
  begin
    dinMeta_r <= memDataIn;
    dinSync_r <= dinMeta_r;
  end

  // ----------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------
  // The read is held one cycle past access time plus two sync stages;
  // slower than the pin allows, but data is always settled when taken
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_r <= asr_pkg::ASR_IDLE;
      cnt_r <= '0;
      wasRead_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        asr_pkg::ASR_IDLE:
        begin
          if (reqValid)
          begin
            cnt_r <= '0;
            wasRead_r <= !reqWrite;
            state_r <= reqWrite ? asr_pkg::ASR_WSET : asr_pkg::ASR_READ;
          end
        end
        asr_pkg::ASR_READ:
        begin
          // Access time plus two synchroniser stages
          if (cnt_r == RdCyc + `ASR_CNT_W'(2))
          begin
            cnt_r <= '0;
            state_r <= asr_pkg::ASR_REC;
          end
          else
            cnt_r <= cnt_r + `ASR_CNT_W'(1);
        end
        asr_pkg::ASR_WSET:
          state_r <= asr_pkg::ASR_WPUL;
        asr_pkg::ASR_WPUL:
        begin
          // Strobe low for the write pulse; data already set up
          if (cnt_r == WpCyc - `ASR_CNT_W'(1))
          begin
            cnt_r <= '0;
            state_r <= asr_pkg::ASR_REC;
          end
          else
            cnt_r <= cnt_r + `ASR_CNT_W'(1);
        end
        asr_pkg::ASR_REC:
        begin
          // Idle gap lets the memory float the bus before reuse
          if (cnt_r == RecCyc - `ASR_CNT_W'(1))
          begin
            cnt_r <= '0;
            state_r <= asr_pkg::ASR_IDLE;
          end
          else
            cnt_r <= cnt_r + `ASR_CNT_W'(1);
        end
        default:
          state_r <= asr_pkg::ASR_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------
  // Memory pins
  // ----------------------------------------------------------
  // Plain levels only; the memory never sees ref_clk itself
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      memAddr <= '0;
      memCsN <= 1'b1;
      memOeN <= 1'b1;
      memWeN <= 1'b1;
      memDataOut <= '0;
      memDataOeN <= 1'b1;
    end
    else
    begin
      case (state_r)
        asr_pkg::ASR_IDLE:
        begin
          if (reqValid)
          begin
            // Address goes out with select, never after it
            memAddr <= reqAddr;
            memCsN <= 1'b0;
            // Enable only for reads; writes keep it high
            memOeN <= reqWrite;
            memDataOut <= reqWdata;
            // Host drives data only with enable high, so no fight
            memDataOeN <= !reqWrite;
          end
        end
        asr_pkg::ASR_WSET:
          memWeN <= 1'b0;
        asr_pkg::ASR_WPUL:
        begin
          if (cnt_r == WpCyc - `ASR_CNT_W'(1))
          begin
            // Strobe and select rise together; address held throughout
            memWeN <= 1'b1;
            memCsN <= 1'b1;
          end
        end
        asr_pkg::ASR_READ:
        begin
          if (cnt_r == RdCyc + `ASR_CNT_W'(2))
          begin
            memCsN <= 1'b1;
            memOeN <= 1'b1;
          end
        end
        asr_pkg::ASR_REC:
          // Data held one cycle after write end: zero hold met
          memDataOeN <= 1'b1;
        default:
        begin
          memCsN <= 1'b1;
          memOeN <= 1'b1;
          memWeN <= 1'b1;
          memDataOeN <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // User answers
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      reqReady <= 1'b0;
      rdValid <= 1'b0;
      rdData <= '0;
    end
    else
    begin
      reqReady <= (state_r == asr_pkg::ASR_REC) &&
        (cnt_r == RecCyc - `ASR_CNT_W'(1)) ||
        (state_r == asr_pkg::ASR_IDLE && !reqValid);
      rdValid <= 1'b0;
      if (state_r == asr_pkg::ASR_READ && wasRead_r &&
          cnt_r == RdCyc + `ASR_CNT_W'(2))
      begin
        rdValid <= 1'b1;
        rdData <= dinSync_r;
      end
    end
  end
endmodule

// ---- core/asr_map.svh ----
// Timing counts and widths for the asynchronous SRAM host controller
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH
`define ASR_ADDR_W 17
`define ASR_DATA_W 8
`define ASR_CLK_PS 8000
// Fastest-grade figures in picoseconds
`define ASR_T_RC_PS 10000
`define ASR_T_WC_PS 10000
`define ASR_T_AA_PS 10000
`define ASR_T_WP_PS 7000
`define ASR_T_DSETUP_PS 5000
`define ASR_T_CHZ_PS 5000
`define ASR_T_OW_PS 3000
// Cycle counts: least times round up
`define ASR_CYC(ps) ((((ps) + `ASR_CLK_PS - 1) / `ASR_CLK_PS) < 1 ? 1 : \
  (((ps) + `ASR_CLK_PS - 1) / `ASR_CLK_PS))
`define ASR_RD_CYC `ASR_CYC(`ASR_T_AA_PS)
`define ASR_WP_CYC `ASR_CYC(`ASR_T_WP_PS)
`define ASR_DSETUP_CYC `ASR_CYC(`ASR_T_DSETUP_PS)
`define ASR_REC_CYC `ASR_CYC(`ASR_T_CHZ_PS)
`define ASR_CNT_W 4
`endif

// ---- core/asr_pkg.sv ----
// Types for the asynchronous SRAM host controller
package asr_pkg;
  typedef enum logic [2:0] {
    ASR_IDLE = 3'b000,
    ASR_READ = 3'b001,
    ASR_WSET = 3'b010,
    ASR_WPUL = 3'b011,
    ASR_REC = 3'b100
  } asr_state_t;
endpackage

// ---- sim/asr_props.sv ----
// Pin-level assertion checker for the SRAM host controller
`timescale 1ns/1ps
`include "asr_map.svh"
module asr_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Watched outputs
  input wire logic rdValid,
  input wire logic [`ASR_ADDR_W-1:0] memAddr,
  input wire logic memCsN,
  input wire logic memOeN,
  input wire logic memWeN,
  input wire logic memDataOeN
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Read window: address and enables steady for access time plus two sync stages
  sequence s_rd_hold;
    ($stable(memAddr) && !memCsN && !memOeN)[*4];
  endsequence
  property p_rd; $fell(memOeN) |=> s_rd_hold ##1 memOeN && memCsN; endproperty
  property p_rv; rdValid |-> $rose(memOeN); endproperty
  property p_oe; !memWeN |-> memOeN && !memCsN; endproperty
  property p_dat; !memWeN |-> !memDataOeN; endproperty
  property p_adr; !memWeN |-> $stable(memAddr); endproperty
  property p_set; $fell(memWeN) |-> $past(memCsN) == 1'b0; endproperty
  property p_pw; $fell(memWeN) |=> memWeN && memCsN; endproperty
  property p_hold; $rose(memWeN) |-> !memDataOeN ##1 memDataOeN; endproperty
  property p_bus; !memDataOeN |-> memOeN; endproperty
  a_rd: assert property (p_rd) else $error("read window broken");
  a_rv: assert property (p_rv) else $error("read data early");
  a_oe: assert property (p_oe) else $error("write enables");
  a_dat: assert property (p_dat) else $error("write data missing");
  a_adr: assert property (p_adr) else $error("address moved");
  a_set: assert property (p_set) else $error("select late");
  a_pw: assert property (p_pw) else $error("write pulse");
  a_hold: assert property (p_hold) else $error("data hold");
  a_bus: assert property (p_bus) else $error("bus fight");
endmodule
bind asr_host asr_props u_props (.ref_clk, .srst, .rdValid, .memAddr,
  .memCsN, .memOeN, .memWeN, .memDataOeN);

// ---- sim/asr_sram_model.sv ----
// Behavioural model of the 128K x 8 static memory
`timescale 1ns/1ps
`include "asr_map.svh"
module asr_sram_model (
  // Memory pins
  input wire logic [`ASR_ADDR_W-1:0] addr,
  input wire logic csN,
  input wire logic oeN,
  input wire logic weN,
  input wire logic [`ASR_DATA_W-1:0] din,
  input wire logic dinOeN,
  output logic [`ASR_DATA_W-1:0] dout
);
  logic [`ASR_DATA_W-1:0] mem [0:131071];
  logic wrAct, rdAct;
  assign wrAct = !csN && !weN;
  assign rdAct = !csN && !oeN && weN;
  // An undriven bus is stored inverted so a missing drive shows up
  always @(negedge wrAct)
    mem[addr] = dinOeN ? ~din : din;
  // A released bus flips rather than keeping the last byte
  initial dout = '0;
  always @(rdAct or addr)
    dout = rdAct ? mem[addr] : ~dout;
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the SRAM host controller
`timescale 1ns/1ps
`include "asr_map.svh"
module testbench;
  logic ref_clk, srst, reqValid, reqWrite, reqReady, rdValid;
  logic [`ASR_ADDR_W-1:0] reqAddr, memAddr;
  logic [`ASR_DATA_W-1:0] reqWdata, rdData, memDataIn, memDataOut;
  logic memCsN, memOeN, memWeN, memDataOeN;
  int err_total, n_compared;
  asr_host DUT (.ref_clk, .srst, .reqValid, .reqWrite, .reqAddr,
    .reqWdata, .reqReady, .rdValid, .rdData, .memAddr, .memCsN,
    .memOeN, .memWeN, .memDataIn, .memDataOut, .memDataOeN);
  asr_sram_model u_mem (.addr(memAddr), .csN(memCsN), .oeN(memOeN),
    .weN(memWeN), .din(memDataOut), .dinOeN(memDataOeN), .dout(memDataIn));
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic wrap_up;
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Bounded wait; a hang ends the run as a mismatch
  task automatic wait_hi(ref logic s);
    int n;
    for (n = 0; s !== 1'b1 && n < 50; n++)
      @(negedge ref_clk);
    if (s !== 1'b1)
    begin
      err_total++;
      wrap_up();
    end
  endtask
  task automatic req(logic wr, logic [16:0] a, logic [7:0] d);
    wait_hi(reqReady);
    reqValid = 1'b1;
    reqWrite = wr;
    reqAddr = a;
    reqWdata = d;
    @(negedge ref_clk);
    reqValid = 1'b0;
  endtask
  task automatic rd(logic [16:0] a, logic [7:0] exp);
    req(1'b0, a, 8'h00);
    wait_hi(rdValid);
    chk("rdData", exp, rdData);
  endtask
  task automatic t_reset;
    chk("memCsN", 8'h01, {7'h0, memCsN});
    chk("memWeN", 8'h01, {7'h0, memWeN});
    chk("reqReady", 8'h00, {7'h0, reqReady});
  endtask
  // Walking address bits plus both ends, written then read back to back
  task automatic t_walk;
    for (int i = 0; i < 17; i++)
      req(1'b1, 17'h00001 << i, 8'(i * 17 + 3));
    req(1'b1, 17'h1ffff, 8'ha5);
    req(1'b1, 17'h00000, 8'h5a);
    for (int i = 0; i < 17; i++)
      rd(17'h00001 << i, 8'(i * 17 + 3));
    rd(17'h1ffff, 8'ha5);
    rd(17'h00000, 8'h5a);
  endtask
  task automatic t_over;
    req(1'b1, 17'h0aaaa, 8'h3c);
    rd(17'h0aaaa, 8'h3c);
    req(1'b1, 17'h0aaaa, 8'hc3);
    rd(17'h0aaaa, 8'hc3);
    repeat (3) @(negedge ref_clk);
    chk("memCsN idle", 8'h01, {7'h0, memCsN});
    chk("memDataOeN idle", 8'h01, {7'h0, memDataOeN});
  endtask
  initial
  begin
    err_total = 0;
    n_compared = 0;
    srst = 1'b1;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqAddr = '0;
    reqWdata = '0;
    repeat (16) @(negedge ref_clk);
    t_reset();
    srst = 1'b0;
    t_walk();
    t_over();
    wrap_up();
  end
endmodule
